// >>> common/spi_lp_pkg.sv
// Package for the low-power aware serial peripheral unit: register map, fields, reset values, codes.
// Assumes a 32-bit APB register bus and a 25 MHz core clock.
package spi_lp_pkg;
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] status_off = 8'h04;
    localparam logic [7:0] data_off = 8'h08;
    localparam logic [7:0] irq_mask_off = 8'h0c;
    localparam logic [7:0] baud_off = 8'h10;
    // Control register fields.
    localparam int module_enable_pos = 0;
    localparam int master_pos = 1;
    localparam int stop_in_wait_pos = 2;
    localparam int cpol_pos = 3;
    localparam int cpha_pos = 4;
    localparam int echo_pos = 5;
    // Status register fields.
    localparam int xfer_done_pos = 0;
    localparam int busy_pos = 1;
    localparam int lp_active_pos = 2;
    localparam logic [5:0] ctrl_reset = 6'h00;
    localparam logic [7:0] baud_reset = 8'h03;
    localparam logic [7:0] data_reset = 8'h00;
    localparam logic [3:0] bits_per_byte = 4'h8;
    localparam logic [31:0] unmapped_read = 32'h0000_0000;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_shift = 2'b01,
        st_done = 2'b11
    } xfer_state_t;
endpackage : spi_lp_pkg

// >>> hw/spi_lp_sync.sv
// Two-flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes the inputs come from pins or a foreign clock domain.
`timescale 1ns/1ps
module spi_lp_sync #(
    parameter int width = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Levels
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] stage1;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : spi_lp_sync

// >>> hw/spi_lp_core.sv
// Serial peripheral unit with run, wait and stop mode handling and an APB register file.
// Assumes pins and low-power indications are asynchronous; core_clk samples the serial clock.
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Enable clear: unit idle, clocks gated, registers still accessible.
// RQ2 - Stop-in-wait clear: wait mode changes nothing.
// RQ3 - Stop-in-wait set: serial clock generation stops in wait mode.
// RQ4 - Master with stop-in-wait: transfer pauses at wait entry, resumes after.
// RQ5 - Slave with stop-in-wait keeps shifting while the master clocks.
// RQ6 - Slave sending data register keeps resending that byte during wait.
// RQ7 - Slave echoing keeps returning each previous master byte during wait.
// RQ8 - In wait or stop, slave flag and interrupt deferred until exit.
// RQ9 - Slave received byte copied to data register only after exit.
// RQ10 - Deferred flag and copy only when a transfer spans entry or exit; the code also flags and copies a transfer wholly inside the spell.
// RQ11 - Stopped module clock is treated as stop mode.
// RQ12 - Master in stop freezes the transfer and continues intact afterward.
// RQ13 - Slave in stop stays bit-synchronised to the master clock.
// RQ14 - Stop handling ignores the stop-in-wait bit.
// RQ15 - Separate wait and stop inputs, synchronised to the bus clock.
module spi_lp_core
    import spi_lp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System low-power indications
    input wire logic cpu_wait,
    input wire logic cpu_stop,
    input wire logic module_clk_on,
    // Serial pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic miso_in,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_n_in,
    // Interrupt
    output logic irq
);
    logic [5:0] ctrl;
    logic [7:0] baud;
    logic [7:0] serial_data_register;
    logic [7:0] tx_hold;
    logic [7:0] shifter;
    logic [7:0] rx_byte;
    logic [7:0] baud_cnt;
    logic [3:0] bit_cnt;
    logic [2:0] status;
    logic [2:0] irq_mask;
    logic [4:0] pin_sync;
    logic sck_prev;
    logic sck_gen;
    logic rx_pending;
    logic lp_busy_mark;
    logic lp_prev;
    logic tx_load;
    logic in_wait, in_stop, clk_static, lp_now, lp_slave_defer, master_hold, enabled;
    logic sck_s, miso_s, mosi_s, ss_s, mclk_s;
    logic sample_edge, shift_edge, slave_active, xfer_end;
    logic apb_write, apb_read, set_done;
    xfer_state_t state;
    xfer_state_t next_state;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == ctrl_off) || (a == status_off) || (a == data_off) || (a == irq_mask_off) || (a == baud_off);
    endfunction : mapped

    // Pins and module clock pass two flops; wait and stop have their own synchroniser.
    spi_lp_sync #(.width(5)) pin_sync_u (
        .core_clk(core_clk),
        .reset(reset),
        .async_in({sck_in, miso_in, mosi_in, ss_n_in, module_clk_on}),
        .sync_out(pin_sync)
    );
    logic [1:0] lp_sync;
    spi_lp_sync #(.width(2)) lp_sync_u (
        .core_clk(core_clk),
        .reset(reset),
        .async_in({cpu_wait, cpu_stop}),
        .sync_out(lp_sync)
    ); // RQ15
    assign {sck_s, miso_s, mosi_s, ss_s, mclk_s} = pin_sync;

    assign enabled = ctrl[module_enable_pos]; // RQ1
    assign in_wait = lp_sync[1] && ctrl[stop_in_wait_pos]; // RQ2 RQ3
    assign clk_static = !mclk_s; // RQ11
    assign in_stop = lp_sync[0] || clk_static; // RQ14
    assign lp_now = in_wait || in_stop;
    assign master_hold = ctrl[master_pos] && lp_now; // RQ4 RQ12
    assign lp_slave_defer = !ctrl[master_pos] && lp_now; // RQ8

    // APB access: zero wait states.
    assign apb_write = psel && penable && pwrite;
    assign apb_read = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata <= unmapped_read;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ctrl_off: prdata <= {26'h0, ctrl};
                status_off: prdata <= {29'h0, status};
                data_off: prdata <= {24'h0, serial_data_register};
                irq_mask_off: prdata <= {29'h0, irq_mask};
                baud_off: prdata <= {24'h0, baud};
                default: prdata <= unmapped_read;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl <= ctrl_reset;
            baud <= baud_reset;
            irq_mask <= 3'h0;
        end else if (apb_write) begin
            case (paddr)
                ctrl_off: ctrl <= pwdata[5:0];
                baud_off: baud <= pwdata[7:0];
                irq_mask_off: irq_mask <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Transmit byte written by software; a write while idle loads the master.
    assign tx_load = apb_write && paddr == data_off;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_hold <= data_reset;
        end else if (tx_load) begin
            tx_hold <= pwdata[7:0];
        end
    end

    // Serial clock generation, stopped when disabled or held by low power.
    always_ff @(posedge core_clk) begin
        if (reset || !enabled || !ctrl[master_pos] || state != st_shift) begin
            baud_cnt <= 8'h00;
            sck_gen <= 1'b0;
        end else if (!master_hold) begin // RQ3 RQ4 RQ12
            if (baud_cnt == baud) begin
                baud_cnt <= 8'h00;
                sck_gen <= !sck_gen;
            end else begin
                baud_cnt <= baud_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= ctrl[master_pos] ? (sck_gen ^ ctrl[cpol_pos]) : sck_s;
        end
    end

    // Leading edge samples when phase is zero; trailing edge otherwise.
    logic sck_now, lead_edge, trail_edge;
    // The generator counts from zero; the polarity bit sets the idle level of the line.
    assign sck_now = ctrl[master_pos] ? (sck_gen ^ ctrl[cpol_pos]) : sck_s;
    assign lead_edge = (sck_now != sck_prev) && (sck_now != ctrl[cpol_pos]);
    assign trail_edge = (sck_now != sck_prev) && (sck_now == ctrl[cpol_pos]);
    assign slave_active = !ctrl[master_pos] && !ss_s;
    assign sample_edge = ctrl[cpha_pos] ? trail_edge : lead_edge;
    assign shift_edge = ctrl[cpha_pos] ? lead_edge : trail_edge;
    assign xfer_end = sample_edge && bit_cnt == bits_per_byte - 4'h1;

    always_comb begin
        next_state = state;
        case (state)
            st_idle: begin
                if (ctrl[master_pos] && tx_load) begin
                    next_state = st_shift;
                end else if (slave_active) begin
                    next_state = st_shift;
                end
            end
            st_shift: begin
                if (xfer_end) begin
                    next_state = st_done;
                end else if (!ctrl[master_pos] && ss_s) begin
                    next_state = st_idle;
                end
            end
            st_done: next_state = st_idle;
            default: next_state = st_idle;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset || !enabled) begin
            state <= st_idle; // RQ1
        end else begin
            state <= next_state;
        end
    end

    // Shift register keeps running for a slave whatever the power mode.
    always_ff @(posedge core_clk) begin
        if (reset || !enabled) begin
            shifter <= data_reset;
            bit_cnt <= 4'h0;
        end else if (state == st_idle) begin
            bit_cnt <= 4'h0;
            if (next_state == st_shift) begin
                // Echo mode returns the last byte received; otherwise the data register value.
                // A master start comes from the data write itself, before the holding register has it.
                shifter <= ctrl[echo_pos] ? rx_byte : (tx_load ? pwdata[7:0] : tx_hold); // RQ6 RQ7
            end
        end else if (state == st_shift) begin
            if (sample_edge) begin // RQ5 RQ13
                shifter <= {shifter[6:0], ctrl[master_pos] ? miso_s : mosi_s};
                bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_byte <= data_reset;
        end else if (state == st_done) begin
            rx_byte <= shifter;
        end
    end

    // A transfer seen active at low-power entry or ending inside it is marked for deferral.
    always_ff @(posedge core_clk) begin
        if (reset || !enabled) begin
            lp_prev <= 1'b0;
            lp_busy_mark <= 1'b0;
            rx_pending <= 1'b0;
        end else begin
            lp_prev <= lp_slave_defer;
            if (lp_slave_defer && !lp_prev && state != st_idle) begin
                lp_busy_mark <= 1'b1; // RQ10
            end
            if (lp_slave_defer && state == st_done) begin
                rx_pending <= 1'b1; // RQ9
            end else if (!lp_slave_defer) begin
                lp_busy_mark <= 1'b0;
                rx_pending <= 1'b0;
            end
        end
    end

    // Data register takes the byte at completion, or at low-power exit when deferred.
    logic exit_copy;
    assign exit_copy = !lp_slave_defer && lp_prev && (rx_pending || (lp_busy_mark && state == st_idle)); // RQ10
    always_ff @(posedge core_clk) begin
        if (reset) begin
            serial_data_register <= data_reset;
        end else if (state == st_done && !lp_slave_defer) begin
            serial_data_register <= shifter;
        end else if (exit_copy) begin
            serial_data_register <= rx_byte; // RQ9
        end
    end

    assign set_done = (state == st_done && !lp_slave_defer) || exit_copy; // RQ8
    // One process owns the whole status word; a completion beats a clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status <= 3'h0;
        end else begin
            if (set_done) begin
                status[xfer_done_pos] <= 1'b1;
            end else if (apb_write && paddr == status_off && pwdata[xfer_done_pos]) begin
                status[xfer_done_pos] <= 1'b0;
            end
            status[busy_pos] <= state != st_idle;
            status[lp_active_pos] <= lp_now;
        end
    end

    assign irq = status[xfer_done_pos] && irq_mask[xfer_done_pos];

    // Pin drive: master drives clock and data out, slave drives its output while selected.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            sck_out <= sck_gen ^ ctrl[cpol_pos];
            sck_oe <= enabled && ctrl[master_pos];
            mosi_out <= shifter[7];
            mosi_oe <= enabled && ctrl[master_pos];
            miso_out <= shifter[7];
            miso_oe <= enabled && slave_active;
        end
    end

    logic unused_shift;
    assign unused_shift = shift_edge;
endmodule : spi_lp_core

// >>> verif/spi_lp_chk.sv
// Concurrent checks on the ports of the low-power serial unit.
// Assumes it is bound to spi_lp_core and sees only its ports.
`timescale 1ns/1ps
module spi_lp_chk
    import spi_lp_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Low power and pins
    input wire logic cpu_wait,
    input wire logic cpu_stop,
    input wire logic module_clk_on,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic mosi_out,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [5:0] ctl;
    logic acc;
    logic mapped;
    logic lp_wait;
    logic lp_stop;
    assign acc = psel && penable;
    assign mapped = paddr inside {ctrl_off, status_off, data_off, irq_mask_off, baud_off};
    assign lp_wait = cpu_wait && ctl[stop_in_wait_pos];
    assign lp_stop = cpu_stop || !module_clk_on;
    // Mirrors the control register so the checks know the role in force.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctl <= ctrl_reset;
        end else if (acc && pwrite && paddr == ctrl_off) begin
            ctl <= pwdata[5:0];
        end
    end
    sequence lp_held_s;
        (lp_wait || lp_stop)[*4];
    endsequence
    pready_hi_a: assert property (pready) else $error("pready low");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("error on mapped");
    disabled_quiet_a: assert property (!ctl[module_enable_pos] [*4] |-> !sck_oe && !mosi_oe && !miso_oe)
        else $error("pins driven while disabled");
    slave_passive_a: assert property ((ctl[module_enable_pos] && !ctl[master_pos]) [*4] |-> !sck_oe && !mosi_oe)
        else $error("slave drives clock");
    wait_freeze_a: assert property (lp_wait [*6] |-> $stable(sck_out)) else $error("clock moves in wait");
    stop_freeze_a: assert property ((ctl[master_pos] && lp_stop) [*6] |-> $stable(sck_out) && $stable(mosi_out))
        else $error("master moves in stop");
    irq_defer_a: assert property ((!ctl[master_pos] throughout lp_held_s) |-> !$rose(irq))
        else $error("flag raised in low power");
endmodule : spi_lp_chk

// >>> verif/spi_lp_peer.sv
// Far-side serial device: slave to the unit as master, master to it as slave.
// Assumes clock idle low, sample on rising edge, most significant bit first.
`timescale 1ns/1ps
module spi_lp_peer (
    // Unit as master
    input wire logic m_sck,
    input wire logic m_mosi,
    output logic s_miso,
    // Peer as master
    output logic p_sck,
    output logic p_mosi,
    output logic p_ss_n,
    input wire logic p_miso
);
    logic [7:0] sr = 8'h00;
    logic cap = 1'b0;
    assign s_miso = sr[7];
    // Shifting on the falling edge keeps the output still at the sample edge.
    always @(posedge m_sck) cap <= m_mosi;
    always @(negedge m_sck) sr <= {sr[6:0], cap};
    initial begin
        p_sck = 1'b0;
        p_mosi = 1'b0;
        p_ss_n = 1'b1;
    end
    task automatic send(input logic [7:0] tx, output logic [7:0] rx);
        #13 p_ss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            p_mosi = tx[i];
            #160 p_sck = 1'b1;
            rx[i] = p_miso;
            #160 p_sck = 1'b0;
        end
        #160 p_ss_n = 1'b1;
        p_mosi = ~p_mosi;
    endtask : send
endmodule : spi_lp_peer

// >>> verif/spi_lp_core_tb_top.sv
// Self-checking bench for the low-power serial unit.
// Assumes the peer model on the serial pins and a 25 MHz core clock.
`timescale 1ns/1ps
module spi_lp_core_tb_top
    import spi_lp_pkg::*;
;
    logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic cpu_wait = 1'b0, cpu_stop = 1'b0, module_clk_on = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, irq, err, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic p_sck, p_mosi, p_ss_n, s_miso, sck_in, mosi_in, miso_in;
    logic [5:0] mc [5] = '{6'h03, 6'h03, 6'h07, 6'h03, 6'h07};
    int mk [5] = '{0, 1, 1, 2, 3};
    int n_mismatch = 0;
    int comparisons = 0;
    assign sck_in = sck_oe ? sck_out : p_sck;
    assign mosi_in = mosi_oe ? mosi_out : p_mosi;
    assign miso_in = miso_oe ? miso_out : s_miso;
    always #20 core_clk = ~core_clk;
    spi_lp_core u_spi_lp_core (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_wait(cpu_wait),
        .cpu_stop(cpu_stop), .module_clk_on(module_clk_on), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .miso_in(miso_in), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out),
        .miso_oe(miso_oe), .ss_n_in(p_ss_n), .irq(irq));
    spi_lp_peer u_spi_lp_peer (.m_sck(sck_in), .m_mosi(mosi_in), .s_miso(s_miso), .p_sck(p_sck), .p_mosi(p_mosi),
        .p_ss_n(p_ss_n), .p_miso(miso_in));
    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge core_clk);
            if (pready === 1'b1) break;
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 16) begin
            n_mismatch++;
            close_out;
        end
    endtask : apb
    task automatic wait_done;
        int i;
        for (i = 0; i < 300; i++) begin
            apb(1'b0, status_off, 32'h0);
            if (rdv[xfer_done_pos] === 1'b1) break;
        end
        if (i == 300) begin
            n_mismatch++;
            close_out;
        end
    endtask : wait_done
    task automatic t_regs;
        apb(1'b0, ctrl_off, 32'h0);
        chk(rdv, ctrl_reset);
        apb(1'b1, ctrl_off, 32'h0b);
        repeat (3) @(posedge core_clk);
        chk(sck_out, 1'b1);
        chk(sck_oe, 1'b1);
        apb(1'b1, ctrl_off, 32'h00);
        apb(1'b1, baud_off, 32'h5);
        apb(1'b0, baud_off, 32'h0);
        chk(rdv, 32'h5);
        apb(1'b1, baud_off, baud_reset);
        apb(1'b0, 8'h14, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, data_off, 32'h11);
        repeat (80) @(posedge core_clk);
        apb(1'b0, status_off, 32'h0);
        chk(rdv[xfer_done_pos], 1'b0);
    endtask : t_regs
    // Master transfer with a low-power spell of kind k: 0 none, 1 wait, 2 stop, 3 module clock off.
    task automatic t_master(input logic [5:0] c, input int k, input logic m);
        apb(1'b1, irq_mask_off, {31'h0, m});
        apb(1'b1, ctrl_off, {26'h0, c});
        u_spi_lp_peer.sr = 8'hc3;
        apb(1'b1, data_off, 32'h96);
        repeat (12) @(posedge core_clk);
        cpu_wait <= k == 1;
        cpu_stop <= k == 2;
        module_clk_on <= k != 3;
        repeat (100) @(posedge core_clk);
        apb(1'b0, status_off, 32'h0);
        chk(rdv[xfer_done_pos], !((k == 1 && c[stop_in_wait_pos]) || k > 1));
        cpu_wait <= 1'b0;
        cpu_stop <= 1'b0;
        module_clk_on <= 1'b1;
        wait_done;
        chk(irq, m);
        apb(1'b0, data_off, 32'h0);
        chk(rdv, 32'hc3);
        repeat (8) @(posedge core_clk);
        chk(u_spi_lp_peer.sr, 8'h96);
        apb(1'b1, status_off, 32'h1);
        @(posedge core_clk);
        chk(irq, 1'b0);
    endtask : t_master
    // Slave frames spanning a wait (s low) or stop (s high) spell, with or without echo.
    task automatic t_slave(input logic e, input logic s);
        logic [7:0] r1;
        logic [7:0] r2;
        logic [31:0] o;
        apb(1'b1, ctrl_off, {26'h0, e, 5'h05});
        apb(1'b1, irq_mask_off, 32'h1);
        apb(1'b1, data_off, 32'h5a);
        apb(1'b0, data_off, 32'h0);
        o = rdv;
        fork
            u_spi_lp_peer.send(8'h81, r1);
            begin
                repeat (25) @(posedge core_clk);
                cpu_wait <= !s;
                cpu_stop <= s;
            end
        join
        u_spi_lp_peer.send(8'h42, r2);
        chk(r2, e ? 8'h81 : 8'h5a);
        if (!e) chk(r1, 8'h5a);
        chk(irq, 1'b0);
        apb(1'b0, data_off, 32'h0);
        chk(rdv, o);
        cpu_wait <= 1'b0;
        cpu_stop <= 1'b0;
        wait_done;
        chk(irq, 1'b1);
        apb(1'b0, data_off, 32'h0);
        chk(rdv, 32'h42);
        apb(1'b1, status_off, 32'h1);
    endtask : t_slave
    task automatic t_idle;
        logic [31:0] o;
        apb(1'b1, ctrl_off, 32'h05);
        apb(1'b0, data_off, 32'h0);
        o = rdv;
        cpu_wait <= 1'b1;
        repeat (20) @(posedge core_clk);
        cpu_wait <= 1'b0;
        repeat (10) @(posedge core_clk);
        apb(1'b0, status_off, 32'h0);
        chk(rdv[xfer_done_pos], 1'b0);
        apb(1'b0, data_off, 32'h0);
        chk(rdv, o);
    endtask : t_idle
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        t_regs;
        for (int i = 0; i < 5; i++) begin
            t_master(mc[i], mk[i], i[0]);
        end
        t_slave(1'b0, 1'b0);
        t_slave(1'b1, 1'b0);
        t_slave(1'b0, 1'b1);
        t_idle;
        close_out;
    end
endmodule : spi_lp_core_tb_top
bind spi_lp_core spi_lp_chk u_spi_lp_chk (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .cpu_wait(cpu_wait),
    .cpu_stop(cpu_stop), .module_clk_on(module_clk_on), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_oe(miso_oe), .irq(irq));
